// >>> eag_pkg.sv
// Package for the effective address generator: widths, mode codes, fields.
// Assumes a 16-bit data path and 16 working registers.
package eag_pkg;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned REG_SEL_W     = 4;
  localparam int unsigned LIT8_W        = 8;
  localparam int unsigned LIT14_W       = 14;
  localparam int unsigned PIVOT_W       = 15;
  localparam int unsigned REV_EN_BIT    = 15;
  localparam logic [3:0]  SEL_X_PTR_A   = 4'h8;
  localparam logic [3:0]  SEL_X_PTR_B   = 4'h9;
  localparam logic [3:0]  SEL_Y_PTR_A   = 4'hA;
  localparam logic [3:0]  SEL_Y_PTR_B   = 4'hB;
  localparam logic [3:0]  SEL_NONE      = 4'hF;
  localparam logic [15:0] RST_WORD      = 16'h0000;

  // Addressing mode of one operand
  typedef enum logic [3:0] {
    AM_DIRECT,
    AM_INDIRECT,
    AM_POST_INC,
    AM_POST_DEC,
    AM_PRE_INC,
    AM_PRE_DEC,
    AM_INDEXED,
    AM_LIT_OFFSET,
    AM_LIT8,
    AM_LIT16
  } eag_mode_e;

  // Operation class being addressed
  typedef enum logic [2:0] {
    OC_TRANSFER,
    OC_MAC,
    OC_JUMP,
    OC_HOLD_OFF,
    OC_OTHER
  } eag_class_e;

  // Dual-operand post-modify choices
  typedef enum logic [2:0] {
    MM_NONE,
    MM_INC2,
    MM_INC4,
    MM_INC6,
    MM_DEC2,
    MM_DEC4,
    MM_DEC6,
    MM_INDEXED
  } eag_mac_mod_e;
endpackage

// >>> eag_core.sv
// Effective address generator: one operand per cycle, registered results.
// Assumes the decoder presents pointer and offset values with the request.
`timescale 1ns/1ps

module eag_core (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_req,
  input  wire eag_pkg::eag_class_e         i_op_class,
  input  wire eag_pkg::eag_mode_e          i_mode,
  input  wire logic                        i_is_write,
  input  wire logic                        i_byte_op,
  input  wire logic [3:0]                  i_ptr_sel,
  input  wire logic [15:0]                 i_ptr_val,
  input  wire logic [3:0]                  i_offset_reg_field,
  input  wire logic [15:0]                 i_offset_val,
  input  wire logic [15:0]                 i_literal,
  input  wire logic [15:0]                 i_step,
  input  wire logic                        i_mac_is_y,
  input  wire eag_pkg::eag_mac_mod_e       i_mac_mod,
  input  wire logic [15:0]                 i_mod_enable_mask,
  input  wire logic [15:0]                 i_mod_start,
  input  wire logic [15:0]                 i_mod_end,
  input  wire logic [3:0]                  i_reversal_pointer_select,
  input  wire logic [15:0]                 i_reversal_modifier_reg,
  input  wire logic [15:0]                 i_x_space_lo,
  input  wire logic [15:0]                 i_x_space_hi,
  input  wire logic [15:0]                 i_y_space_lo,
  input  wire logic [15:0]                 i_y_space_hi,
  output logic                             o_valid,
  output logic [15:0]                      o_ea,
  output logic                             o_to_x_unit,
  output logic                             o_to_y_unit,
  output logic                             o_wb_en,
  output logic [3:0]                       o_wb_sel,
  output logic [15:0]                      o_wb_val,
  output logic [3:0]                       o_offset_sel,
  output logic [15:0]                      o_operand,
  output logic                             o_is_literal,
  output logic                             o_illegal,
  output logic                             o_space_err,
  output logic                             o_rev_used,
  output logic                             o_mod_used
);
  import eag_pkg::*;

  logic        mac_op;
  logic        illegal_c;
  logic        mac_y_c;
  logic [15:0] step_c;
  logic [15:0] offs_c;
  logic [15:0] mod_addr_c;
  logic [15:0] ea_c;
  logic [15:0] new_ptr_c;
  logic [15:0] rev_mod_c;
  logic [15:0] oper_c;
  logic        lit_c;
  logic        pre_c;
  logic        post_c;
  logic        incr_c;
  logic        modify_c;
  logic        mod_on_c;
  logic        rev_on_c;
  logic        mod_hit_c;
  logic        in_x_c;
  logic        in_y_c;
  logic        space_err_c;
  logic [15:0] buf_len_c;

  assign mac_op = (i_op_class == OC_MAC);

  // Only the pivot is reversed; pointer stays in normal order
  // Pivot is bits 14:0, enable sits at bit 15
  genvar gi;
  generate
    for (gi = 0; gi < PIVOT_W; gi++) begin : g_rev
      assign rev_mod_c[gi] = i_reversal_modifier_reg[PIVOT_W-1-gi];
    end
  endgenerate
  assign rev_mod_c[15] = 1'b0;

  // Dual-operand pointers fixed to their unit by register number
  always_comb begin
    mac_y_c = i_mac_is_y;
    if (mac_op) begin
      mac_y_c = (i_ptr_sel == SEL_Y_PTR_A) || (i_ptr_sel == SEL_Y_PTR_B);
    end
  end

  // Step and offset per mode; dual-operand modes restricted
  always_comb begin
    step_c = i_step;
    offs_c = RST_WORD;
    pre_c  = (i_mode == AM_PRE_INC) || (i_mode == AM_PRE_DEC);
    post_c = (i_mode == AM_POST_INC) || (i_mode == AM_POST_DEC);
    incr_c = (i_mode == AM_PRE_INC) || (i_mode == AM_POST_INC);
    if (mac_op) begin
      pre_c  = 1'b0;
      post_c = (i_mac_mod != MM_NONE) && (i_mac_mod != MM_INDEXED);
      incr_c = (i_mac_mod == MM_INC2) || (i_mac_mod == MM_INC4) ||
               (i_mac_mod == MM_INC6);
      unique case (i_mac_mod)
        MM_INC2, MM_DEC2: step_c = 16'h0002;
        MM_INC4, MM_DEC4: step_c = 16'h0004;
        MM_INC6, MM_DEC6: step_c = 16'h0006;
        default:          step_c = 16'h0000;
      endcase
      if (i_mac_mod == MM_INDEXED) begin
        offs_c = i_offset_val;
      end
    end else if (i_mode == AM_INDEXED) begin
      offs_c = i_offset_val;
    end else if (i_mode == AM_LIT_OFFSET) begin
      offs_c = i_literal;
    end
    modify_c = pre_c || post_c;
  end

  // Illegal dual-operand use: wrong pointer or indexing
  always_comb begin
    illegal_c = 1'b0;
    if (mac_op) begin
      illegal_c = (i_ptr_sel < SEL_X_PTR_A) || (i_ptr_sel > SEL_Y_PTR_B);
      if (i_mac_mod == MM_INDEXED && i_ptr_sel != SEL_X_PTR_B &&
          i_ptr_sel != SEL_Y_PTR_B) begin
        illegal_c = 1'b1;
      end
    end
  end

  // Reversal: non-dual-operand ops, word writes, pre/post increment only
  assign rev_on_c = (i_reversal_pointer_select != SEL_NONE) &&
                    i_reversal_modifier_reg[REV_EN_BIT] &&
                    (i_reversal_pointer_select == i_ptr_sel) &&
                    incr_c && (pre_c || post_c) && !mac_op &&
                    i_is_write && !i_byte_op;

  // Modulo on any working register, per-register enable
  assign mod_on_c  = i_mod_enable_mask[i_ptr_sel];
  assign buf_len_c = 16'(i_mod_end - i_mod_start + 16'h0001);

  // Modified address before correction
  always_comb begin
    if (modify_c) begin
      mod_addr_c = incr_c ? 16'(i_ptr_val + step_c)
                          : 16'(i_ptr_val - step_c);
    end else begin
      mod_addr_c = 16'(i_ptr_val + offs_c);
    end
  end

  // Crossing past a boundary, not only equal, is caught
  always_comb begin
    mod_hit_c = 1'b0;
    new_ptr_c = mod_addr_c;
    if (mod_on_c && modify_c && incr_c && mod_addr_c > i_mod_end) begin
      mod_hit_c = 1'b1;
      new_ptr_c = 16'(mod_addr_c - buf_len_c);
    end else if (mod_on_c && modify_c && !incr_c &&
                 mod_addr_c < i_mod_start) begin
      mod_hit_c = 1'b1;
      new_ptr_c = 16'(mod_addr_c + buf_len_c);
    end else if (mod_on_c && !modify_c && mod_addr_c > i_mod_end) begin
      mod_hit_c = 1'b1;
      new_ptr_c = 16'(mod_addr_c - buf_len_c);
    end
    if (rev_on_c) begin
      // Reversal wins; pivot scaled to bytes, LSB clear
      mod_hit_c = 1'b0;
      new_ptr_c = 16'((i_ptr_val + {rev_mod_c[14:0], 1'b0}) & 16'hFFFE);
    end
  end

  // Effective address: pre and offset forms use new value
  always_comb begin
    lit_c  = 1'b0;
    oper_c = RST_WORD;
    ea_c   = i_ptr_val;
    unique case (i_mode)
      AM_LIT8:   begin
        lit_c  = 1'b1;
        oper_c = {8'h00, i_literal[LIT8_W-1:0]};
      end
      AM_LIT16:  begin
        lit_c  = 1'b1;
        oper_c = i_literal;
      end
      AM_DIRECT: oper_c = i_ptr_val;
      default:   ea_c = (pre_c || !modify_c) ? new_ptr_c : i_ptr_val;
    endcase
    if (mac_op) begin
      lit_c = 1'b0;
      ea_c  = (i_mac_mod == MM_INDEXED) ? new_ptr_c : i_ptr_val;
    end
    if (i_op_class == OC_JUMP) begin
      lit_c  = 1'b1;
      oper_c = i_literal; // Signed 16-bit destination
    end else if (i_op_class == OC_HOLD_OFF) begin
      lit_c  = 1'b1;
      oper_c = {2'b00, i_literal[LIT14_W-1:0]};
    end
  end

  // Flag dual-operand addresses outside the owning space
  assign in_x_c = (ea_c >= i_x_space_lo) && (ea_c <= i_x_space_hi) &&
                  (new_ptr_c >= i_x_space_lo) && (new_ptr_c <= i_x_space_hi);
  assign in_y_c = (ea_c >= i_y_space_lo) && (ea_c <= i_y_space_hi) &&
                  (new_ptr_c >= i_y_space_lo) && (new_ptr_c <= i_y_space_hi);
  assign space_err_c = mac_op && (mac_y_c ? !in_y_c : !in_x_c);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid      <= 1'b0;
      o_ea         <= RST_WORD;
      o_operand    <= RST_WORD;
      o_is_literal <= 1'b0;
      o_illegal    <= 1'b0;
      o_space_err  <= 1'b0;
      o_to_x_unit  <= 1'b0;
      o_to_y_unit  <= 1'b0;
      o_offset_sel <= 4'h0;
    end else begin
      o_valid      <= i_req;
      o_ea         <= ea_c;
      o_operand    <= oper_c;
      o_is_literal <= i_req && lit_c;
      o_illegal    <= i_req && illegal_c;
      o_space_err  <= i_req && space_err_c;
      o_to_x_unit  <= i_req && (!mac_op ? !i_mac_is_y : !mac_y_c);
      o_to_y_unit  <= i_req && (!mac_op ? i_mac_is_y : mac_y_c);
      o_offset_sel <= i_offset_reg_field; // One field, both operands
    end
  end

  // Pointer write-back only for pre/post modify forms
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_en    <= 1'b0;
      o_wb_sel   <= 4'h0;
      o_wb_val   <= RST_WORD;
      o_rev_used <= 1'b0;
      o_mod_used <= 1'b0;
    end else begin
      o_wb_en    <= i_req && modify_c && !illegal_c && !lit_c;
      o_wb_sel   <= i_ptr_sel;
      o_wb_val   <= new_ptr_c;
      o_rev_used <= i_req && rev_on_c;
      o_mod_used <= i_req && mod_hit_c;
    end
  end

  property p_wb_only_modify;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_req && !modify_c) |=> !o_wb_en;
  endproperty
  a_wb_only_modify: assert property (p_wb_only_modify)
    else $error("pointer written back without modify mode");

  property p_offset_no_wb;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_req && !mac_op && i_mode == AM_INDEXED) |=> !o_wb_en;
  endproperty
  a_offset_no_wb: assert property (p_offset_no_wb)
    else $error("indexed access changed pointer");

  property p_route_x;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_req && mac_op && (i_ptr_sel == SEL_X_PTR_A ||
       i_ptr_sel == SEL_X_PTR_B)) |=> (o_to_x_unit && !o_to_y_unit);
  endproperty
  a_route_x: assert property (p_route_x)
    else $error("X prefetch pointer not routed to X unit");

  property p_rev_write_only;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_req && (!i_is_write || i_byte_op)) |=> !o_rev_used;
  endproperty
  a_rev_write_only: assert property (p_rev_write_only)
    else $error("bit reversal on read or byte access");

  property p_rev_lsb;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_rev_used |-> (o_wb_val[0] == 1'b0 && !o_mod_used);
  endproperty
  a_rev_lsb: assert property (p_rev_lsb)
    else $error("reversed address odd or modulo also applied");

  property p_rev_sel_none;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_req && i_reversal_pointer_select == SEL_NONE) |=> !o_rev_used;
  endproperty
  a_rev_sel_none: assert property (p_rev_sel_none)
    else $error("reversal active with select 1111");

  property p_mac_bad_ptr;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_req && mac_op && i_mac_mod == MM_INDEXED &&
       i_ptr_sel == SEL_X_PTR_A) |=> o_illegal;
  endproperty
  a_mac_bad_ptr: assert property (p_mac_bad_ptr)
    else $error("indexed via first X pointer not flagged");

  property p_hold_off_lit;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_req && i_op_class == OC_HOLD_OFF) |=>
        (o_is_literal && o_operand[15:14] == 2'b00);
  endproperty
  a_hold_off_lit: assert property (p_hold_off_lit)
    else $error("hold-off literal wider than 14 bits");

  property p_mod_wrap;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (o_mod_used && o_wb_en) |->
        (o_wb_val >= $past(i_mod_start) && o_wb_val <= $past(i_mod_end));
  endproperty
  a_mod_wrap: assert property (p_mod_wrap)
    else $error("modulo wrap left the buffer");

endmodule // eag_core

// >>> eag_mem_model.sv
// Partner model: X and Y data spaces behind the address generator.
// Assumes one access per o_valid and space limits held by the bench.
`timescale 1ns/1ps
module eag_mem_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_valid,
  input  wire logic        i_to_x,
  input  wire logic        i_to_y,
  input  wire logic [15:0] i_ea,
  input  wire logic [15:0] i_x_lo,
  input  wire logic [15:0] i_x_hi,
  output logic      [7:0]  o_x_hits,
  output logic      [7:0]  o_y_hits,
  output logic      [7:0]  o_out_hits
);
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_x_hits   <= 8'h00;
      o_y_hits   <= 8'h00;
      o_out_hits <= 8'h00;
    end else if (i_valid) begin
      o_x_hits <= o_x_hits + 8'(i_to_x);
      o_y_hits <= o_y_hits + 8'(i_to_y);
      // X access outside X space counts as a fault
      if (i_to_x && (i_ea < i_x_lo || i_ea > i_x_hi))
        o_out_hits <= o_out_hits + 8'h01;
    end
  end
endmodule // eag_mem_model

// >>> effective_address_generator_tb.sv
// Self-checking bench for the effective address generator.
// Assumes outputs are registered one cycle after each request.
`timescale 1ns/1ps
module effective_address_generator_tb;
  import eag_pkg::*;
  logic         i_core_clk, i_rst_n, i_req, i_is_write, i_byte_op;
  logic         i_mac_is_y, o_valid, o_to_x_unit, o_to_y_unit, o_wb_en;
  logic         o_is_literal, o_illegal, o_space_err, o_rev_used, o_mod_used;
  eag_class_e   i_op_class;
  eag_mode_e    i_mode;
  eag_mac_mod_e i_mac_mod;
  logic [3:0]   i_ptr_sel, i_offset_reg_field, i_reversal_pointer_select;
  logic [3:0]   o_wb_sel, o_offset_sel;
  logic [15:0]  i_ptr_val, i_offset_val, i_literal, i_step, i_mod_enable_mask;
  logic [15:0]  i_mod_start, i_mod_end, i_reversal_modifier_reg, d;
  logic [15:0]  i_x_space_lo, i_x_space_hi, i_y_space_lo, i_y_space_hi;
  logic [15:0]  o_ea, o_wb_val, o_operand;
  logic [7:0]   x_hits, y_hits, out_hits, hx, hy, ho;
  int           mismatches, n_tests;

  eag_core eag_core_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_req(i_req), .i_op_class(i_op_class), .i_mode(i_mode),
    .i_is_write(i_is_write), .i_byte_op(i_byte_op), .i_ptr_sel(i_ptr_sel),
    .i_ptr_val(i_ptr_val), .i_offset_reg_field(i_offset_reg_field),
    .i_offset_val(i_offset_val), .i_literal(i_literal), .i_step(i_step),
    .i_mac_is_y(i_mac_is_y), .i_mac_mod(i_mac_mod),
    .i_mod_enable_mask(i_mod_enable_mask), .i_mod_start(i_mod_start),
    .i_mod_end(i_mod_end),
    .i_reversal_pointer_select(i_reversal_pointer_select),
    .i_reversal_modifier_reg(i_reversal_modifier_reg),
    .i_x_space_lo(i_x_space_lo), .i_x_space_hi(i_x_space_hi),
    .i_y_space_lo(i_y_space_lo), .i_y_space_hi(i_y_space_hi),
    .o_valid(o_valid), .o_ea(o_ea), .o_to_x_unit(o_to_x_unit),
    .o_to_y_unit(o_to_y_unit), .o_wb_en(o_wb_en), .o_wb_sel(o_wb_sel),
    .o_wb_val(o_wb_val), .o_offset_sel(o_offset_sel), .o_operand(o_operand),
    .o_is_literal(o_is_literal), .o_illegal(o_illegal),
    .o_space_err(o_space_err), .o_rev_used(o_rev_used),
    .o_mod_used(o_mod_used));

  eag_mem_model eag_mem_model_inst (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_valid(o_valid), .i_to_x(o_to_x_unit),
    .i_to_y(o_to_y_unit), .i_ea(o_ea), .i_x_lo(i_x_space_lo),
    .i_x_hi(i_x_space_hi), .o_x_hits(x_hits), .o_y_hits(y_hits),
    .o_out_hits(out_hits));

  always #2.5 i_core_clk = ~i_core_clk;

  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_f(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Neutral request: plain indirect read through register 1
  task automatic clr();
    i_req = 1'b0;
    i_op_class = OC_TRANSFER;
    i_mode = AM_INDIRECT;
    {i_is_write, i_byte_op, i_mac_is_y} = 3'h0;
    {i_ptr_sel, i_offset_reg_field} = 8'h10;
    {i_ptr_val, i_offset_val, i_literal} = 48'h0;
    i_step = 16'h0002;
    i_mac_mod = MM_NONE;
    i_mod_enable_mask = 16'h0000;
    i_mod_start = 16'h0100;
    i_mod_end = 16'h010F;
    i_reversal_pointer_select = 4'hF;
    i_reversal_modifier_reg = 16'h0000;
    {i_x_space_lo, i_x_space_hi} = 32'h0000_7FFF;
    {i_y_space_lo, i_y_space_hi} = 32'h8000_FFFF;
  endtask

  // One request; returns with its result settled
  task automatic go();
    @(posedge i_core_clk);
    #1 i_req = 1'b1;
    @(posedge i_core_clk);
    #1 i_req = 1'b0;
  endtask

  task automatic t_modulo(input logic [3:0] s, input eag_mode_e m,
                          input logic [15:0] p, input logic [15:0] e);
    clr();
    i_ptr_sel = s;
    i_mod_enable_mask = 16'h0001 << s;
    i_mode = m;
    i_ptr_val = p;
    i_step = 16'h0004;
    go();
    chk_v(o_wb_val, e);
    chk_f(o_mod_used, 1'b1);
    chk_f(o_wb_en, 1'b1);
    chk_v(o_wb_sel, {12'h000, s});
  endtask

  task automatic t_rev(input logic w, input logic b, input logic [3:0] s,
                       input logic [15:0] r, input eag_mode_e m,
                       input logic e);
    clr();
    {i_is_write, i_byte_op} = {w, b};
    {i_ptr_sel, i_reversal_pointer_select} = {s, s};
    i_reversal_modifier_reg = r;
    i_mode = m;
    i_ptr_val = 16'h0100;
    // Plain step crosses the buffer edge, so modulo competes
    i_step = 16'h0010;
    i_mod_enable_mask = 16'h0001 << s;
    go();
    chk_f(o_rev_used, e);
    chk_f(o_mod_used, ~e);
    // Pivot 0x4010 reversed over 15 bits is 0x0401, twice that in bytes
    if (e) begin
      chk_v(o_wb_val, 16'h0902);
      chk_v(o_ea, (m == AM_PRE_INC) ? 16'h0902 : 16'h0100);
    end
  endtask

  task automatic t_lit(input eag_class_e c, input eag_mode_e m,
                       input logic [15:0] e);
    clr();
    i_op_class = c;
    i_mode = m;
    i_literal = 16'hFFAB;
    go();
    chk_v(o_operand, e);
    chk_f(o_is_literal, 1'b1);
  endtask

  task automatic t_mac_idx(input logic [3:0] s, input logic e);
    clr();
    i_op_class = OC_MAC;
    i_mac_mod = MM_INDEXED;
    i_ptr_sel = s;
    {i_ptr_val, i_offset_val} = 32'h1000_0008;
    go();
    chk_f(o_illegal, e);
    chk_f(o_space_err, s == 4'hA);
    chk_f(o_wb_en, 1'b0);
    if (!e)
      chk_v(o_ea, 16'h1008);
  endtask

  initial begin
    #20000;
    mismatches++;
    print_verdict();
  end

  initial begin
    {i_core_clk, i_rst_n, mismatches, n_tests} = '0;
    clr();
    repeat (5) @(posedge i_core_clk);
    chk_f(o_valid, 1'b0);
    chk_f(o_wb_en, 1'b0);
    #1 i_rst_n = 1'b1;
    i_mode = AM_POST_INC;
    i_ptr_val = 16'h0100;
    go();
    chk_f(o_valid, 1'b1);
    chk_v(o_ea, 16'h0100);
    chk_v(o_wb_val, 16'h0102);
    chk_f(o_wb_en, 1'b1);
    t_modulo(4'h3, AM_POST_INC, 16'h010E, 16'h0102);
    t_modulo(4'hD, AM_POST_DEC, 16'h0102, 16'h010E);
    clr();
    i_mode = AM_INDEXED;
    {i_ptr_val, i_offset_reg_field} = {16'h010C, 4'h5};
    {i_offset_val, i_mod_enable_mask} = 32'h0008_0002;
    go();
    chk_v(o_ea, 16'h0104);
    chk_f(o_wb_en, 1'b0);
    chk_v(o_offset_sel, 4'h5);
    t_rev(1'b1, 1'b0, 4'h2, 16'hC010, AM_POST_INC, 1'b1);
    t_rev(1'b1, 1'b0, 4'h2, 16'hC010, AM_PRE_INC, 1'b1);
    t_rev(1'b1, 1'b0, 4'h2, 16'hC010, AM_POST_DEC, 1'b0);
    t_rev(1'b1, 1'b1, 4'h2, 16'hC010, AM_POST_INC, 1'b0);
    t_rev(1'b0, 1'b0, 4'h2, 16'hC010, AM_POST_INC, 1'b0);
    t_rev(1'b1, 1'b0, 4'h2, 16'h4010, AM_POST_INC, 1'b0);
    t_rev(1'b1, 1'b0, 4'hF, 16'hC010, AM_POST_INC, 1'b0);
    // Last request's access must reach the model before the snapshot
    @(posedge i_core_clk);
    #1 {hx, hy, ho} = {x_hits, y_hits, out_hits};
    for (int k = 0; k < 6; k++) begin
      clr();
      i_op_class = OC_MAC;
      i_ptr_sel = 4'h8 + 4'(k % 4);
      i_ptr_val = i_ptr_sel[1] ? 16'h9000 : 16'h1000;
      i_mac_mod = eag_mac_mod_e'(k + 1);
      d = 16'(k < 3 ? 2 * (k + 1) : 4 - 2 * k);
      go();
      chk_f(o_to_x_unit, ~i_ptr_sel[1]);
      chk_f(o_to_y_unit, i_ptr_sel[1]);
      chk_v(o_wb_val, i_ptr_val + d);
      chk_f(o_space_err, 1'b0);
    end
    @(posedge i_core_clk);
    #1 chk_v(16'(x_hits - hx), 16'h0004);
    chk_v(16'(y_hits - hy), 16'h0002);
    chk_v(16'(out_hits - ho), 16'h0000);
    t_mac_idx(4'h8, 1'b1);
    t_mac_idx(4'hA, 1'b1);
    t_mac_idx(4'h9, 1'b0);
    t_mac_idx(4'h3, 1'b1);
    t_lit(OC_TRANSFER, AM_LIT8, 16'h00AB);
    t_lit(OC_TRANSFER, AM_LIT16, 16'hFFAB);
    t_lit(OC_JUMP, AM_LIT16, 16'hFFAB);
    t_lit(OC_HOLD_OFF, AM_LIT16, 16'h3FAB);
    print_verdict();
  end
endmodule // effective_address_generator_tb
